/* File: fault_resp_map.svh */
`ifndef FAULT_RESP_MAP_SVH
`define FAULT_RESP_MAP_SVH

// Register offsets (byte addresses)
`define FR_CTRL_OFS 8'h00
`define FR_FLAGS_OFS 8'h04
`define FR_IRQ_STAT_OFS 8'h08
`define FR_IRQ_MASK_OFS 8'h0c

// Control register fields
`define FR_CTRL_BUS_LIM_EN 0
`define FR_CTRL_SAT_EN 1
`define FR_CTRL_OV_EN 2
`define FR_CTRL_OV_SEL 3
`define FR_CTRL_OC_MODE_LO 4
`define FR_CTRL_OC_MODE_HI 5
`define FR_CTRL_OC_LVL_LO 8
`define FR_CTRL_OC_LVL_HI 11
`define FR_CTRL_OC_DEG_LO 12
`define FR_CTRL_OC_DEG_HI 13
`define FR_CTRL_CLEAR 31
`define FR_CTRL_RESET 32'h0000_0004

// Fault flag register fields
`define FR_FLG_CTRL_FAULT 0
`define FR_FLG_DRV_FAULT 1
`define FR_FLG_BUS_LIM 2
`define FR_FLG_CUR_SAT 3
`define FR_FLG_SPD_SAT 4
`define FR_FLG_OVERTEMP 5
`define FR_FLG_BUCK_UV 6
`define FR_FLG_PUMP_UV 7
`define FR_FLG_OV 8
`define FR_FLG_OC 9
`define FR_FLG_FET_OC_LO 10
`define FR_FLG_FET_OC_HI 15

// Interrupt status and mask fields
`define FR_IRQ_CTRL 0
`define FR_IRQ_DRV 1
`define FR_IRQ_OC 2
`define FR_IRQ_BUCK 3
`define FR_IRQ_MASK_RESET 4'h0

// Timing
`define FR_CLK_NS 20
`define FR_OC_DEG0_NS 200
`define FR_OC_DEG1_NS 500
`define FR_OC_DEG2_NS 1000
`define FR_OC_DEG3_NS 2000
`define FR_RETRY_NS 5000000

`endif

/* File: fault_resp_pkg.sv */
package fault_resp_pkg;
  typedef enum logic [1:0] {
    OC_LATCHED = 2'b00,
    OC_RETRY = 2'b01,
    OC_REPORT = 2'b10,
    OC_DISABLED = 2'b11
  } oc_mode_e;

  typedef enum logic [1:0] {
    OCS_IDLE = 2'b00,
    OCS_LATCH = 2'b01,
    OCS_RETRY = 2'b10
  } oc_state_e;
endpackage

/* File: motor_fault_response.sv */
// How it works
// - Bus current over limit, when enabled: pin low, controller fault, speed restricted.
// - Current-loop saturation, when enabled: pin and flag, FETs stay active.
// - Speed-loop saturation, when enabled: pin and flag, motor keeps driving.
// - FET overtemperature: outputs Hi-Z, pin low, driver flag, auto recovery.
// - Motor supply undervoltage: FETs, pump, logic off; block reset except synchronisers and output stage.
// - Analog rail undervoltage: FETs, pump, logic off; block reset except synchronisers and output stage.
// - Buck feedback low: buck fault flagged, regulator keeps regulating.
// - Pump undervoltage: FETs off, pin low, flags set, auto resume.
// - Pump undervoltage flag stays set until the clear command.
// - Overvoltage: FETs off, pin low, flags set, resume on clear condition.
// - Overvoltage flag stays latched until the clear command.
// - Overvoltage enable at zero suppresses overvoltage protection.
// - Threshold select bit picks the 22 V or 34 V comparator.
// - Overcurrent only after exceeding level longer than deglitch time.
// - Level, deglitch programmable; latched, retry, report, disabled modes.
// - Latched overcurrent: FETs off until condition gone and clear issued.
// - Retry overcurrent: resume after retry time, overcurrent flags stay.
`timescale 1ns/1ns
`default_nettype none
`include "fault_resp_map.svh"

module motor_fault_response
  import fault_resp_pkg::*;
#(
  parameter int RETRY_CYCLES = `FR_RETRY_NS / `FR_CLK_NS
) (
  input wire logic clk_sys_i,                // 50 MHz system clock
  input wire logic sys_rst_i,                // Synchronous reset, high
  input wire logic [7:0] reg_addr_i,         // Register byte address
  input wire logic [31:0] reg_wdata_i,       // Write data
  input wire logic reg_wr_i,                 // Write strobe
  input wire logic reg_rd_i,                 // Read strobe
  output logic [31:0] reg_rdata_o,           // Read data, cycle after strobe
  input wire logic bus_over_limit_i,         // Supply current above limit
  input wire logic cur_loop_sat_i,           // Current loop saturated
  input wire logic spd_loop_sat_i,           // Speed loop saturated
  input wire logic fet_overtemp_shutdown_i,  // FET temperature trip
  input wire logic vm_uvlo_i,                // Motor supply undervoltage
  input wire logic analog_supply_rail_uv_i,  // Analog rail undervoltage
  input wire logic buck_feedback_uv_i,       // Buck feedback below threshold
  input wire logic pump_uv_i,                // Charge pump undervoltage
  input wire logic vm_over_22_i,             // Supply above 22 V
  input wire logic vm_over_34_i,             // Supply above 34 V
  input wire logic [5:0] fet_over_level_i,   // Per-FET current above level
  output logic [3:0] overcurrent_level_o,    // Level to comparators
  output logic speed_limit_o,                // Restrict speed or current
  output logic fets_hiz_o,                   // All outputs high impedance
  output logic charge_pump_en_o,             // Charge pump enable
  output logic logic_reset_o,                // Digital controller held reset
  output logic fault_pin_n_o,                // Fault pin drive value
  output logic fault_pin_n_oe_n_o,           // Low while pin pulled low
  output logic irq_o                         // Level interrupt
);

  localparam int DEG0 = (`FR_OC_DEG0_NS + `FR_CLK_NS - 1) / `FR_CLK_NS;
  localparam int DEG1 = (`FR_OC_DEG1_NS + `FR_CLK_NS - 1) / `FR_CLK_NS;
  localparam int DEG2 = (`FR_OC_DEG2_NS + `FR_CLK_NS - 1) / `FR_CLK_NS;
  localparam int DEG3 = (`FR_OC_DEG3_NS + `FR_CLK_NS - 1) / `FR_CLK_NS;
  localparam int RW = $clog2(RETRY_CYCLES + 1);

  if (RETRY_CYCLES < 1) begin : g_chk
    $error("RETRY_CYCLES must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [15:0] raw_w;
  logic [15:0] meta_reg;
  logic [15:0] sync_reg;
  assign raw_w = {fet_over_level_i, vm_over_34_i, vm_over_22_i, pump_uv_i,
                  buck_feedback_uv_i, analog_supply_rail_uv_i, vm_uvlo_i,
                  fet_overtemp_shutdown_i, spd_loop_sat_i, cur_loop_sat_i,
                  bus_over_limit_i};

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      meta_reg <= 16'h0000;
      sync_reg <= 16'h0000;
    end else begin
      meta_reg <= raw_w;
      sync_reg <= meta_reg;
    end
  end

  wire bus_s = sync_reg[0];
  wire cur_s = sync_reg[1];
  wire spd_s = sync_reg[2];
  wire ot_s = sync_reg[3];
  wire vm_uv_s = sync_reg[4];
  wire av_uv_s = sync_reg[5];
  wire buck_s = sync_reg[6];
  wire pump_s = sync_reg[7];
  wire ov22_s = sync_reg[8];
  wire ov34_s = sync_reg[9];
  wire [5:0] fet_s = sync_reg[15:10];

  // Supply loss puts all state past the synchronisers, except the output registers, into reset
  wire supply_lost = vm_uv_s | av_uv_s;
  wire core_rst = sys_rst_i | supply_lost;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  logic [31:0] ctrl_reg;
  logic [3:0] irq_mask_reg;
  logic [3:0] irq_stat_reg;
  logic clr_reg;
  logic [31:0] flags_w;

  wire wr_ctrl = reg_wr_i & (reg_addr_i == `FR_CTRL_OFS);
  wire wr_istat = reg_wr_i & (reg_addr_i == `FR_IRQ_STAT_OFS);
  wire wr_imask = reg_wr_i & (reg_addr_i == `FR_IRQ_MASK_OFS);

  wire bus_en = ctrl_reg[`FR_CTRL_BUS_LIM_EN];
  wire sat_en = ctrl_reg[`FR_CTRL_SAT_EN];
  wire ov_en = ctrl_reg[`FR_CTRL_OV_EN];
  wire ov_sel = ctrl_reg[`FR_CTRL_OV_SEL];
  wire [1:0] deg_sel = ctrl_reg[`FR_CTRL_OC_DEG_HI:`FR_CTRL_OC_DEG_LO];
  oc_mode_e oc_mode;
  assign oc_mode = oc_mode_e'(ctrl_reg[`FR_CTRL_OC_MODE_HI:`FR_CTRL_OC_MODE_LO]);

  logic [31:0] rd_mux;
  assign rd_mux = (reg_addr_i == `FR_CTRL_OFS) ? {1'b0, ctrl_reg[30:0]} :
                  (reg_addr_i == `FR_FLAGS_OFS) ? flags_w :
                  (reg_addr_i == `FR_IRQ_STAT_OFS) ? {28'h0000000, irq_stat_reg} :
                  (reg_addr_i == `FR_IRQ_MASK_OFS) ? {28'h0000000, irq_mask_reg} :
                  32'h0000_0000;

  always_ff @(posedge clk_sys_i) begin
    if (core_rst) begin
      ctrl_reg <= `FR_CTRL_RESET;
      irq_mask_reg <= `FR_IRQ_MASK_RESET;
      clr_reg <= 1'b0;
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= {1'b0, reg_wdata_i[30:0]};
      end
      if (wr_imask) begin
        irq_mask_reg <= reg_wdata_i[3:0];
      end
      clr_reg <= wr_ctrl & reg_wdata_i[`FR_CTRL_CLEAR];
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controller faults, live while the condition lasts
  wire bus_act = bus_en & bus_s;
  wire cur_act = sat_en & cur_s;
  wire spd_act = sat_en & spd_s;
  wire ctrl_fault = bus_act | cur_act | spd_act;

  ////////////////////////////////////////////////////////////////////////////
  // Overvoltage and charge pump
  wire ov_act = ov_en & (ov_sel ? ov34_s : ov22_s);
  logic pump_flag_reg;
  logic ov_flag_reg;

  always_ff @(posedge clk_sys_i) begin
    if (core_rst) begin
      pump_flag_reg <= 1'b0;
      ov_flag_reg <= 1'b0;
    end else begin
      pump_flag_reg <= pump_s | (pump_flag_reg & ~clr_reg);
      ov_flag_reg <= ov_act | (ov_flag_reg & ~clr_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent deglitch, one counter per FET
  logic [7:0] deg_lim;
  assign deg_lim = (deg_sel == 2'b00) ? 8'(DEG0) :
                   (deg_sel == 2'b01) ? 8'(DEG1) :
                   (deg_sel == 2'b10) ? 8'(DEG2) : 8'(DEG3);

  logic [5:0] oc_hit;
  logic [5:0] fet_oc_reg;
  wire oc_on = (oc_mode != OC_DISABLED);

  for (genvar i = 0; i < 6; i++) begin : g_fet
    logic [7:0] deg_cnt_reg;
    always_ff @(posedge clk_sys_i) begin
      if (core_rst || !fet_s[i]) begin
        deg_cnt_reg <= 8'h00;
      end else if (deg_cnt_reg < deg_lim) begin
        deg_cnt_reg <= deg_cnt_reg + 8'h01;
      end
    end
    // Recognised only once the level stood past the deglitch time
    assign oc_hit[i] = fet_s[i] & (deg_cnt_reg >= deg_lim);
    always_ff @(posedge clk_sys_i) begin
      if (core_rst) begin
        fet_oc_reg[i] <= 1'b0;
      end else begin
        fet_oc_reg[i] <= (oc_hit[i] & oc_on) | (fet_oc_reg[i] & ~clr_reg);
      end
    end
  end

  wire oc_evt = (|oc_hit) & oc_on;
  wire oc_flag = |fet_oc_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent response machine
  oc_state_e oc_state_reg;
  oc_state_e oc_state_next;
  logic [RW-1:0] retry_cnt_reg;
  wire retry_done = (retry_cnt_reg == RW'(RETRY_CYCLES - 1));

  always_comb begin
    oc_state_next = oc_state_reg;
    unique case (oc_state_reg)
      OCS_IDLE: begin
        if (oc_evt && oc_mode == OC_LATCHED) begin
          oc_state_next = OCS_LATCH;
        end else if (oc_evt && oc_mode == OC_RETRY) begin
          oc_state_next = OCS_RETRY;
        end
      end
      OCS_LATCH: begin
        if (clr_reg && !(|fet_s)) begin
          oc_state_next = OCS_IDLE;
        end
      end
      OCS_RETRY: begin
        if (retry_done) begin
          oc_state_next = OCS_IDLE;
        end
      end
      default: begin
        oc_state_next = OCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (core_rst) begin
      oc_state_reg <= OCS_IDLE;
      retry_cnt_reg <= '0;
    end else begin
      oc_state_reg <= oc_state_next;
      retry_cnt_reg <= (oc_state_reg == OCS_RETRY) ? retry_cnt_reg + RW'(1) : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver fault, outputs and fault pin
  wire oc_block = (oc_state_reg != OCS_IDLE);
  wire drv_fault = ot_s | pump_s | ov_act | oc_block;
  wire oc_report = oc_flag & (oc_mode == OC_REPORT);
  wire pin_low = ctrl_fault | drv_fault | oc_report;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fets_hiz_o <= 1'b1;
      charge_pump_en_o <= 1'b0;
      logic_reset_o <= 1'b1;
      fault_pin_n_oe_n_o <= 1'b1;
      speed_limit_o <= 1'b0;
      overcurrent_level_o <= 4'h0;
    end else begin
      fets_hiz_o <= supply_lost | drv_fault;
      charge_pump_en_o <= ~supply_lost;
      logic_reset_o <= supply_lost;
      fault_pin_n_oe_n_o <= ~(pin_low & ~supply_lost);
      speed_limit_o <= bus_act & ~supply_lost;
      overcurrent_level_o <= ctrl_reg[`FR_CTRL_OC_LVL_HI:`FR_CTRL_OC_LVL_LO];
    end
  end
  assign fault_pin_n_o = 1'b0;

  // Buck low is only reported; regulation is left running
  assign flags_w = {16'h0000, fet_oc_reg, oc_flag, ov_flag_reg, pump_flag_reg,
                    buck_s, ot_s, spd_act, cur_act, bus_act, drv_fault, ctrl_fault};

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  logic [3:0] ev_lvl_w;
  logic [3:0] ev_prev_reg;
  logic [3:0] ev_rise_w;
  assign ev_lvl_w = {buck_s, oc_flag, drv_fault, ctrl_fault};
  assign ev_rise_w = ev_lvl_w & ~ev_prev_reg;

  always_ff @(posedge clk_sys_i) begin
    if (core_rst) begin
      ev_prev_reg <= 4'h0;
      irq_stat_reg <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      ev_prev_reg <= ev_lvl_w;
      irq_stat_reg <= ev_rise_w | (irq_stat_reg & ~(wr_istat ? reg_wdata_i[3:0] : 4'h0));
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (core_rst);

  a_bus_restrict: assert property (
    bus_en && bus_s |=> speed_limit_o && (!fets_hiz_o || $past(drv_fault)))
    else $error("bus limit did not restrict speed");

  a_bus_release: assert property (
    !bus_act |=> !speed_limit_o)
    else $error("speed restriction held after bus current fell");

  a_cur_sat_pin: assert property (
    sat_en && cur_s |-> flags_w[`FR_FLG_CUR_SAT] ##1 !fault_pin_n_oe_n_o)
    else $error("current loop saturation not reported");

  a_spd_sat_pin: assert property (
    sat_en && spd_s && !drv_fault |=> !fault_pin_n_oe_n_o && !fets_hiz_o)
    else $error("speed loop saturation handling wrong");

  a_overtemp_hiz: assert property (
    ot_s |=> fets_hiz_o && !fault_pin_n_oe_n_o)
    else $error("overtemperature did not disable outputs");

  // Own disable: supply loss is itself part of the default one
  a_supply_reset: assert property (
    disable iff (sys_rst_i)
    supply_lost |=> fets_hiz_o && logic_reset_o && !charge_pump_en_o && fault_pin_n_oe_n_o)
    else $error("supply loss did not stop the output stage");

  a_buck_run: assert property (
    buck_s && !drv_fault |=> !fets_hiz_o)
    else $error("buck undervoltage stopped the output stage");

  a_pump_stop: assert property (
    pump_s |-> flags_w[`FR_FLG_DRV_FAULT]
      ##1 fets_hiz_o && !fault_pin_n_oe_n_o && pump_flag_reg)
    else $error("pump undervoltage did not stop the outputs");

  a_pump_hold: assert property (
    pump_flag_reg && !pump_s && !clr_reg |=> pump_flag_reg)
    else $error("pump undervoltage flag lost before clear");

  a_ov_trip: assert property (
    ov_en && (ov_sel ? ov34_s : ov22_s) |=> fets_hiz_o && !fault_pin_n_oe_n_o && ov_flag_reg)
    else $error("overvoltage did not stop the outputs");

  a_ov_hold: assert property (
    ov_flag_reg && !clr_reg |=> ov_flag_reg)
    else $error("overvoltage flag lost before clear");

  a_ov_disable: assert property (
    !ov_en && !$past(ov_en) |-> !ov_act && !$rose(ov_flag_reg))
    else $error("overvoltage acted while disabled");

  // Shortest deglitch setting is ten cycles
  a_oc_deglitch: assert property (
    $rose(fet_oc_reg[0]) |-> $past(fet_s[0], 1) && $past(fet_s[0], 11))
    else $error("overcurrent flagged before the deglitch time");

  a_latch_hold: assert property (
    oc_state_reg == OCS_LATCH && !clr_reg |=> oc_state_reg == OCS_LATCH && fets_hiz_o)
    else $error("latched overcurrent released without clear");

  a_retry_bound: assert property (
    oc_state_reg == OCS_RETRY |-> retry_cnt_reg < RW'(RETRY_CYCLES))
    else $error("retry period overran");

  a_retry_release: assert property (
    oc_state_reg == OCS_RETRY && retry_cnt_reg == RW'(RETRY_CYCLES - 1)
      |=> oc_state_reg == OCS_IDLE)
    else $error("retry period did not end on time");

  a_report_run: assert property (
    oc_mode == OC_REPORT && oc_state_reg == OCS_IDLE && oc_flag |=> !fault_pin_n_oe_n_o)
    else $error("report-only overcurrent not on pin");

  a_oc_disabled: assert property (
    oc_mode == OC_DISABLED && oc_state_reg == OCS_IDLE
      |=> oc_state_reg == OCS_IDLE && !$rose(oc_flag))
    else $error("disabled overcurrent still acted");

endmodule
`default_nettype wire

/* File: fault_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

module fault_host_model (
  input wire logic fault_pin_n_i,     // Design drive value
  input wire logic fault_pin_n_oe_n_i,// Low while design pulls the pin
  output logic pin_level_o            // Resolved wire level
);
  // Pull-up on the board: a released pin reads high
  assign pin_level_o = fault_pin_n_oe_n_i ? 1'b1 : fault_pin_n_i;
endmodule

`default_nettype wire

/* File: motor_fault_response_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fault_resp_map.svh"

module motor_fault_response_tb;
  import fault_resp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [9:0] cond = 10'h0;
  logic [5:0] fet = 6'h0;
  logic [31:0] rdata;
  logic [31:0] ctrl;
  logic [3:0] lvl;
  logic spd_lim, hiz, pump_en, lrst, pin_drv, pin_oe_n, irq, pin_level;
  int errors = 0;
  int checks = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  motor_fault_response #(.RETRY_CYCLES(8)) dut_u (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .bus_over_limit_i(cond[0]),
    .cur_loop_sat_i(cond[1]), .spd_loop_sat_i(cond[2]), .fet_overtemp_shutdown_i(cond[3]),
    .vm_uvlo_i(cond[4]), .analog_supply_rail_uv_i(cond[5]), .buck_feedback_uv_i(cond[6]),
    .pump_uv_i(cond[7]), .vm_over_22_i(cond[8]), .vm_over_34_i(cond[9]),
    .fet_over_level_i(fet), .overcurrent_level_o(lvl), .speed_limit_o(spd_lim),
    .fets_hiz_o(hiz), .charge_pump_en_o(pump_en), .logic_reset_o(lrst),
    .fault_pin_n_o(pin_drv), .fault_pin_n_oe_n_o(pin_oe_n), .irq_o(irq));

  fault_host_model host_u (
    .fault_pin_n_i(pin_drv), .fault_pin_n_oe_n_i(pin_oe_n), .pin_level_o(pin_level));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic setc(input int i, input logic v);
    @(posedge clk_sys_i);
    cond[i] <= v;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic set_ctrl(input logic [31:0] v);
    ctrl = v;
    wr_reg(`FR_CTRL_OFS, v);
  endtask

  task automatic clr();
    wr_reg(`FR_CTRL_OFS, ctrl | 32'h8000_0000);
    wt(5);
  endtask

  // Flags under mask, output stage and resolved fault pin
  task automatic look(input logic [31:0] m, input logic [31:0] e, input logic h, input logic p);
    logic [31:0] d;
    rd_reg(`FR_FLAGS_OFS, d);
    chk(d & m, e);
    chk({31'h0, hiz}, {31'h0, h});
    chk({31'h0, pin_level}, {31'h0, p});
  endtask

  task automatic oc_pulse(input logic [5:0] f, input int n);
    @(posedge clk_sys_i);
    fet <= f;
    wt(n);
    look(32'hfe00, 32'h0, 1'b0, 1'b1);
    @(posedge clk_sys_i);
    fet <= 6'h0;
    wt(5);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd_reg(`FR_CTRL_OFS, d);
    chk(d, `FR_CTRL_RESET);
    wr_reg(8'h10, 32'hffff_ffff);
    rd_reg(8'h10, d);
    chk(d, 32'h0);
    look(32'hffff, 32'h0, 1'b0, 1'b1);
    // Bus current limit enabled, condition raised then released
    set_ctrl(32'h5);
    setc(0, 1'b1);
    wt(5);
    chk({31'h0, spd_lim}, 32'h1);
    look(32'h5, 32'h5, 1'b0, 1'b0);
    setc(0, 1'b0);
    wt(5);
    chk({31'h0, spd_lim}, 32'h0);
    look(32'h5, 32'h0, 1'b0, 1'b1);
    // Loop saturation flags
    set_ctrl(32'h6);
    setc(1, 1'b1);
    wt(5);
    look(32'h9, 32'h9, 1'b0, 1'b0);
    setc(1, 1'b0);
    setc(2, 1'b1);
    wt(5);
    look(32'h18, 32'h10, 1'b0, 1'b0);
    setc(2, 1'b0);
    wt(5);
    look(32'h19, 32'h0, 1'b0, 1'b1);
    // Overtemperature with interrupt masked, unmasked, cleared
    wr_reg(`FR_IRQ_STAT_OFS, 32'hf);
    setc(3, 1'b1);
    wt(5);
    look(32'h22, 32'h22, 1'b1, 1'b0);
    chk({31'h0, irq}, 32'h0);
    wr_reg(`FR_IRQ_MASK_OFS, 32'h2);
    wt(2);
    chk({31'h0, irq}, 32'h1);
    setc(3, 1'b0);
    wt(5);
    look(32'h22, 32'h0, 1'b0, 1'b1);
    wr_reg(`FR_IRQ_STAT_OFS, 32'h2);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    // Pump undervoltage, sticky flag
    setc(7, 1'b1);
    wt(5);
    look(32'h82, 32'h82, 1'b1, 1'b0);
    setc(7, 1'b0);
    wt(5);
    look(32'h82, 32'h80, 1'b0, 1'b1);
    clr();
    look(32'h80, 32'h0, 1'b0, 1'b1);
    // Overvoltage: 22 V trip, latch, 34 V select, disable
    set_ctrl(32'h4);
    setc(8, 1'b1);
    wt(5);
    look(32'h102, 32'h102, 1'b1, 1'b0);
    setc(8, 1'b0);
    wt(5);
    look(32'h102, 32'h100, 1'b0, 1'b1);
    clr();
    look(32'h100, 32'h0, 1'b0, 1'b1);
    set_ctrl(32'hc);
    setc(8, 1'b1);
    wt(5);
    look(32'h100, 32'h0, 1'b0, 1'b1);
    setc(9, 1'b1);
    wt(5);
    look(32'h100, 32'h100, 1'b1, 1'b0);
    setc(9, 1'b0);
    wt(5);
    clr();
    look(32'h102, 32'h0, 1'b0, 1'b1);
    set_ctrl(32'h8);
    setc(9, 1'b1);
    wt(5);
    look(32'h102, 32'h0, 1'b0, 1'b1);
    setc(8, 1'b0);
    setc(9, 1'b0);
    // Overcurrent latched: short pulses ignored at two deglitch settings
    set_ctrl(32'h3a04);
    wt(1);
    chk({28'h0, lvl}, 32'ha);
    oc_pulse(6'h04, 60);
    set_ctrl(32'h0504);
    wt(1);
    chk({28'h0, lvl}, 32'h5);
    oc_pulse(6'h04, 5);
    @(posedge clk_sys_i);
    fet <= 6'h04;
    wt(20);
    look(32'h1202, 32'h1202, 1'b1, 1'b0);
    @(posedge clk_sys_i);
    fet <= 6'h0;
    wt(5);
    look(32'h1200, 32'h1200, 1'b1, 1'b0);
    clr();
    look(32'h1202, 32'h0, 1'b0, 1'b1);
    // Overcurrent retry
    set_ctrl(32'h0514);
    @(posedge clk_sys_i);
    fet <= 6'h01;
    wt(15);
    chk({31'h0, hiz}, 32'h1);
    @(posedge clk_sys_i);
    fet <= 6'h0;
    wt(4);
    chk({31'h0, hiz}, 32'h1);
    wt(3);
    chk({31'h0, hiz}, 32'h0);
    wt(13);
    look(32'h602, 32'h600, 1'b0, 1'b1);
    clr();
    look(32'h600, 32'h0, 1'b0, 1'b1);
    // Report-only then disabled
    set_ctrl(32'h1524);
    @(posedge clk_sys_i);
    fet <= 6'h02;
    wt(20);
    look(32'ha00, 32'h0, 1'b0, 1'b1);
    wt(8);
    look(32'ha00, 32'ha00, 1'b0, 1'b0);
    set_ctrl(32'h2534);
    fet <= 6'h0;
    clr();
    oc_pulse(6'h02, 20);
    // Buck undervoltage keeps the stage running
    setc(6, 1'b1);
    wt(5);
    rd_reg(`FR_FLAGS_OFS, d);
    chk(d & 32'h42, 32'h40);
    chk({31'h0, hiz}, 32'h0);
    setc(6, 1'b0);
    // Supply and analog rail loss reset the block
    for (int i = 4; i < 6; i++) begin
      set_ctrl(32'h1);
      setc(i, 1'b1);
      wt(5);
      chk({28'h0, lrst, pump_en, hiz, pin_level}, 32'hb);
      setc(i, 1'b0);
      wt(5);
      rd_reg(`FR_CTRL_OFS, d);
      chk(d, `FR_CTRL_RESET);
      chk({28'h0, lrst, pump_en, hiz, pin_level}, 32'h5);
    end
    finish_test();
  end

  initial begin
    #400000;
    errors++;
    finish_test();
  end
endmodule

`default_nettype wire
